// ==== inc/sstx_map.svh ====
// Register offsets, field positions, control reset value, service vector and word width of the slave transmitter
`ifndef SSTX_MAP_SVH
`define SSTX_MAP_SVH
`define SSTX_OFF_CTRL    12'h000
`define SSTX_OFF_HOLD    12'h004
`define SSTX_OFF_STAT    12'h008
`define SSTX_OFF_IMASK   12'h00C
`define SSTX_OFF_ISTAT   12'h010
`define SSTX_OFF_WAKE    12'h014
// Control fields
`define SSTX_CTL_SLAVE   0
`define SSTX_CTL_TXEN    1
`define SSTX_CTL_SLEEP   2
`define SSTX_CTL_TX_IRQ_ENABLE    3
`define SSTX_CTL_PERIPHERAL_IRQ_ENABLE    4
`define SSTX_CTL_GIE     5
// Status / interrupt fields
`define SSTX_ST_TBE      0
`define SSTX_ST_WAKE     1
`define SSTX_ST_SHBUSY   2
`define SSTX_ST_HOLDFULL 3
`define SSTX_CTRL_RST    32'h0000_0000
`define SSTX_ISR_VECTOR  16'h0004
`define SSTX_WORD_BITS   8
`endif

// ==== inc/sstx_pkg.sv ====
// Types of the synchronous slave transmitter
package sstx_pkg;
  typedef enum logic [1:0] {
    SH_IDLE,
    SH_SHIFT
  } sstx_shst_t;
endpackage

// ==== rtl/sstx_shifter.sv ====
// Shift register clocked by sampled edges of the external shift clock
`timescale 1ns/1ps
`include "sstx_map.svh"
module sstx_shifter #(
  parameter int W = `SSTX_WORD_BITS
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         enable,
  input  wire logic         fallEdge,
  input  wire logic         loadReq,
  input  wire logic [W-1:0] loadData,
  output logic              busy,
  output logic              dataOut,
  output logic              wordDone
);
  typedef struct packed {
    sstx_pkg::sstx_shst_t st;
    logic [W-1:0]         sh;
    logic [3:0]           cnt;
    logic                 dout;
    logic                 done;
  } sstx_shs_t;
  sstx_shs_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    unique case (s_q.st)
      sstx_pkg::SH_IDLE: begin
        if (loadReq) begin
          s_d.st   = sstx_pkg::SH_SHIFT;
          s_d.sh   = loadData;
          s_d.dout = loadData[0];
          s_d.cnt  = 4'h0;
        end
      end
      sstx_pkg::SH_SHIFT: begin
        // One bit leaves per external clock pulse; next bit is set up on the falling edge
        if (!enable) begin
          s_d.st = sstx_pkg::SH_IDLE;
        end else if (fallEdge) begin // R12
          if (s_q.cnt == 4'(W - 1)) begin
            s_d.st   = sstx_pkg::SH_IDLE;
            s_d.done = 1'b1;
          end else begin
            s_d.sh   = {1'b0, s_q.sh[W-1:1]};
            s_d.dout = s_q.sh[1];
            s_d.cnt  = s_q.cnt + 4'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.dout <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy     = (s_q.st == sstx_pkg::SH_SHIFT);
  assign dataOut  = s_q.dout;
  assign wordDone = s_q.done;

  AST_ONE_BIT_PER_CLOCK: assert property (@(posedge clk) disable iff (!rst_n) // R12
    (busy && enable && fallEdge && s_q.cnt != 4'(W - 1)) |=> (s_q.cnt == $past(s_q.cnt) + 4'h1))
    else $error("bit counter did not advance on a clock pulse");
  AST_DONE_AFTER_WORD: assert property (@(posedge clk) disable iff (!rst_n) // R12
    wordDone |-> $past(s_q.cnt) == 4'(W - 1))
    else $error("word ended before all bits shifted");
endmodule

// ==== rtl/sstx_slave_tx.sv ====
// Synchronous slave transmitter that keeps shifting during sleep, with AHB-Lite registers
//
// The implementer's own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "sstx_map.svh"
// Operation
// R1: In sleep with slave transmit set up, accept external clocks and drive data.
// R2: When the shift register is emptied, reload it from the holding buffer.
// R3: Set the buffer empty flag at the moment of that reload.
// R4: The buffer empty flag set during sleep wakes the processor.
// R5: Holding buffer then takes another byte; writing it clears the flag.
// R6: Software sets slave transmit configuration before sleep.
// R7: Software fills shift register and holding buffer before sleep.
// R8: Software sets transmit and peripheral interrupt enables if interrupt wanted.
// R9: On wake resume after sleep; with global enable, call vector 0004h.
// R10: Only synchronous slave mode keeps running during sleep.
// R11: Slave mode shifts on the externally supplied clock.
// R12: Eight-bit words, one bit out per external clock pulse.
module sstx_slave_tx (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        shiftClkIn,
  output logic             serialDataOut,
  output logic             serialDataOe_n,
  output logic             wakeReq,
  output logic             isrCall,
  output logic      [15:0] isrVector,
  output logic             irq
);
  typedef struct packed {
    logic [1:0]  ckSync;
    logic        ckPrev;
    logic [7:0]  hold;
    logic        holdFull;
    logic [5:0]  ctrl;
    logic [3:0]  istat;
    logic [3:0]  imask;
    logic        wrPend;
    logic        rdPend;
    logic [11:0] addr;
    logic [31:0] rdata;
    logic        dout;
    logic        oe_n;
    logic        wake;
    logic        isr;
    logic        irq;
  } sstx_st_t;
  sstx_st_t s_q, s_d;

  logic       shBusy;
  logic       shOut;
  logic       shDone;
  logic       loadReq;
  logic       fallEdge;
  logic       slaveTx;
  logic       tbeSet;
  logic       holdWr;
  logic [3:0] wrBits;

  assign slaveTx  = s_q.ctrl[`SSTX_CTL_SLAVE] && s_q.ctrl[`SSTX_CTL_TXEN];
  assign fallEdge = s_q.ckPrev && !s_q.ckSync[1];
  // Reload when the shifter is idle: both on startup and right after a word completes
  assign loadReq  = slaveTx && !shBusy && s_q.holdFull; // R2
  assign tbeSet   = loadReq; // R3
  assign holdWr   = s_q.wrPend && (s_q.addr == `SSTX_OFF_HOLD);
  assign wrBits   = hwdata[3:0];

  sstx_shifter #(.W(`SSTX_WORD_BITS)) u_shifter (
    .clk      (clk),
    .rst_n    (rst_n),
    .enable   (slaveTx),
    .fallEdge (fallEdge), // R11
    .loadReq  (loadReq),
    .loadData (s_q.hold),
    .busy     (shBusy),
    .dataOut  (shOut),
    .wordDone (shDone)
  );

  function automatic logic [31:0] regRead(input sstx_st_t s, input logic busy,
                                          input logic [11:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `SSTX_OFF_CTRL:  v = {26'h000_0000, s.ctrl};
      `SSTX_OFF_HOLD:  v = {24'h00_0000, s.hold};
      `SSTX_OFF_STAT:  v = {28'h000_0000, s.holdFull, busy, s.wake, s.istat[`SSTX_ST_TBE]};
      `SSTX_OFF_IMASK: v = {28'h000_0000, s.imask};
      `SSTX_OFF_ISTAT: v = {28'h000_0000, s.istat};
      `SSTX_OFF_WAKE:  v = {15'h0000, s.isr, `SSTX_ISR_VECTOR};
      default:         v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_comb begin
    s_d = s_q;
    s_d.ckSync = {s_q.ckSync[0], shiftClkIn};
    s_d.ckPrev = s_q.ckSync[1];
    // Address phase capture; only whole-word transfers are expected
    s_d.wrPend = 1'b0;
    s_d.rdPend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      s_d.addr   = {haddr[11:2], 2'b00};
      s_d.wrPend = hwrite;
      s_d.rdPend = !hwrite;
    end
    if (s_q.rdPend) begin
      s_d.rdata = 32'h0000_0000;
    end
    // Fetch from the new address in its address phase so the word stands in the data phase
    if (hsel && hready && htrans[1] && !hwrite) begin
      s_d.rdata = regRead(s_q, shBusy, {haddr[11:2], 2'b00});
    end
    if (loadReq) begin
      s_d.holdFull = 1'b0;
    end
    if (s_q.wrPend) begin
      unique case (s_q.addr)
        `SSTX_OFF_CTRL:  s_d.ctrl = hwdata[5:0];
        `SSTX_OFF_HOLD: begin
          s_d.hold     = hwdata[7:0];
          s_d.holdFull = 1'b1; // R5
        end
        `SSTX_OFF_IMASK: s_d.imask = wrBits;
        `SSTX_OFF_ISTAT: s_d.istat = s_q.istat & ~wrBits;
        `SSTX_OFF_WAKE:  s_d.isr = 1'b0;
        default: ;
      endcase
    end
    // Flag is clear after reset; a fresh byte or a one written to ISTAT bit 0 clears it, a reload sets it
    if (holdWr) begin
      s_d.istat[`SSTX_ST_TBE] = 1'b0; // R5
    end
    if (tbeSet) begin
      s_d.istat[`SSTX_ST_TBE] = 1'b1; // R3
    end
    // Wake only in slave mode; other modes need the system clock that sleep stops
    if (tbeSet && s_q.ctrl[`SSTX_CTL_SLEEP]) begin // R4 R10
      s_d.istat[`SSTX_ST_WAKE] = 1'b1;
      s_d.wake = 1'b1;
      s_d.ctrl[`SSTX_CTL_SLEEP] = 1'b0;
      if (s_q.ctrl[`SSTX_CTL_TX_IRQ_ENABLE] && s_q.ctrl[`SSTX_CTL_PERIPHERAL_IRQ_ENABLE] && s_q.ctrl[`SSTX_CTL_GIE]) begin
        s_d.isr = 1'b1; // R9
      end
    end else if (s_q.wrPend && s_q.addr == `SSTX_OFF_WAKE) begin
      s_d.wake = 1'b0;
    end
    s_d.dout = slaveTx ? shOut : 1'b1; // R1
    s_d.oe_n = !slaveTx;
    s_d.irq  = |(s_d.istat & s_d.imask);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
      s_q.dout <= 1'b1;
      s_q.oe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign hrdata         = s_q.rdata;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign serialDataOut  = s_q.dout;
  assign serialDataOe_n = s_q.oe_n;
  assign wakeReq        = s_q.wake;
  assign isrCall        = s_q.isr;
  assign isrVector      = `SSTX_ISR_VECTOR;
  assign irq            = s_q.irq;

  AST_RELOAD_ON_EMPTY: assert property (@(posedge clk) disable iff (!rst_n) // R2
    loadReq |=> shBusy && (!s_q.holdFull || $past(holdWr)))
    else $error("holding byte not moved into empty shifter");
  AST_FLAG_ON_RELOAD: assert property (@(posedge clk) disable iff (!rst_n) // R3
    loadReq |=> s_q.istat[`SSTX_ST_TBE])
    else $error("empty flag not set at reload");
  AST_WAKE_ON_FLAG: assert property (@(posedge clk) disable iff (!rst_n) // R4
    (loadReq && s_q.ctrl[`SSTX_CTL_SLEEP]) |=> wakeReq && !s_q.ctrl[`SSTX_CTL_SLEEP])
    else $error("no wake after flag set in sleep");
  AST_NO_WAKE_AWAKE: assert property (@(posedge clk) disable iff (!rst_n) // R4
    (!wakeReq && !(tbeSet && s_q.ctrl[`SSTX_CTL_SLEEP])) |=> !wakeReq)
    else $error("wake request without a flag set in sleep");
  AST_WRITE_CLEARS_FLAG: assert property (@(posedge clk) disable iff (!rst_n) // R5
    (holdWr && !loadReq) |=> !s_q.istat[`SSTX_ST_TBE] && s_q.holdFull)
    else $error("holding write did not clear empty flag");
  AST_ISR_NEEDS_GIE: assert property (@(posedge clk) disable iff (!rst_n) // R9
    $rose(s_q.isr) |-> $past(s_q.ctrl[`SSTX_CTL_GIE]) && $past(s_q.ctrl[`SSTX_CTL_TX_IRQ_ENABLE]))
    else $error("service call without global enable");
  AST_ISR_ON_WAKE: assert property (@(posedge clk) disable iff (!rst_n) // R9
    (tbeSet && s_q.ctrl[`SSTX_CTL_SLEEP] && s_q.ctrl[`SSTX_CTL_TX_IRQ_ENABLE]
     && s_q.ctrl[`SSTX_CTL_PERIPHERAL_IRQ_ENABLE] && s_q.ctrl[`SSTX_CTL_GIE]) |=> isrCall)
    else $error("no service call on wake with all enables set");
  AST_WAKE_WRITE_CLEARS: assert property (@(posedge clk) disable iff (!rst_n) // R9
    (s_q.wrPend && s_q.addr == `SSTX_OFF_WAKE && !(tbeSet && s_q.ctrl[`SSTX_CTL_SLEEP]))
    |=> !wakeReq && !isrCall)
    else $error("wake write did not clear the wake request");
  AST_DRIVE_IN_SLAVE: assert property (@(posedge clk) disable iff (!rst_n) // R1
    slaveTx |=> !serialDataOe_n)
    else $error("data pin not driven in slave transmit");
  AST_IDLE_LINE_HIGH: assert property (@(posedge clk) disable iff (!rst_n) // R10
    !slaveTx |=> serialDataOut && serialDataOe_n)
    else $error("data pin not released outside slave transmit");
  AST_NO_SHIFT_OUT_OF_MODE: assert property (@(posedge clk) disable iff (!rst_n) // R10
    !slaveTx |=> !shBusy)
    else $error("shifter running outside slave mode");
  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rst_n) // R4
    irq == |(s_q.istat & s_q.imask))
    else $error("interrupt output mismatch");

  COV_WORD_DONE: cover property (@(posedge clk) disable iff (!rst_n) shDone);
  COV_WAKE: cover property (@(posedge clk) disable iff (!rst_n) $rose(wakeReq));
  COV_ISR: cover property (@(posedge clk) disable iff (!rst_n) $rose(isrCall));
  COV_RELOAD_IN_SLEEP: cover property (@(posedge clk) disable iff (!rst_n)
    loadReq && s_q.ctrl[`SSTX_CTL_SLEEP]);
  COV_WAKE_NO_ISR: cover property (@(posedge clk) disable iff (!rst_n) $rose(wakeReq) && !isrCall);
endmodule

// ==== verification/sstx_ext_master.sv ====
// External synchronous master that clocks one byte out of the slave transmitter
`timescale 1ns/1ps
module sstx_ext_master (
  input  wire logic       go,
  input  wire logic       slow,
  input  wire logic       dataIn,
  output logic            shiftClk,
  output logic      [7:0] rxByte,
  output logic            frameDone
);
  int half;
  // Clock idles low between frames; offset keeps edges off the system clock grid
  initial begin
    shiftClk = 1'b0;
    rxByte = 8'h00;
    frameDone = 1'b0;
    forever begin
      @(posedge go);
      frameDone = 1'b0;
      // Link period is fixed; a slow start only lengthens the idle lead-in
      half = 80;
      #(slow ? 487 : 7);
      for (int i = 0; i < 8; i++) begin
        #(half) shiftClk = 1'b1;
        rxByte[i] = dataIn;
        #(half) shiftClk = 1'b0;
      end
      frameDone = 1'b1;
    end
  end
endmodule

// ==== verification/sstx_slave_tx_bench.sv ====
// Self-checking bench for the sleep-mode slave transmitter
`timescale 1ns/1ps
`include "sstx_map.svh"
module sstx_slave_tx_bench;
  logic        clk, rst_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        shiftClkIn, serialDataOut, serialDataOe_n, wakeReq, isrCall, irq;
  logic [15:0] isrVector;
  logic        go, slow, frameDone;
  logic [7:0]  rxByte;
  int          numErrors, cmpCount;

  sstx_slave_tx DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .shiftClkIn(shiftClkIn),
    .serialDataOut(serialDataOut), .serialDataOe_n(serialDataOe_n), .wakeReq(wakeReq),
    .isrCall(isrCall), .isrVector(isrVector), .irq(irq));
  sstx_ext_master master (.go(go), .slow(slow), .dataIn(serialDataOut),
    .shiftClk(shiftClkIn), .rxByte(rxByte), .frameDone(frameDone));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmpCount++;
    if (got !== exp) begin
      numErrors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Address phase held until hready, then data phase held until hready
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {20'h0_0000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic frame(input logic s, input logic [7:0] exp);
    slow <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    wait (frameDone === 1'b1);
    repeat (10) @(posedge clk);
    chk("rxByte", {24'h00_0000, exp}, {24'h00_0000, rxByte});
  endtask

  task automatic reset_values;
    chk("oe_n", 32'h0000_0001, {31'h0, serialDataOe_n});
    chk("dataOut", 32'h0000_0001, {31'h0, serialDataOut});
    chk("hresp", 32'h0000_0000, {31'h0, hresp});
    chk("isrVector", 32'h0000_0004, {16'h0000, isrVector});
    ahb(1'b0, `SSTX_OFF_CTRL, 32'h0000_0000);
    chk("ctrl", 32'h0000_0000, rd);
  endtask

  task automatic sleep_transmit;
    ahb(1'b1, `SSTX_OFF_CTRL, 32'h0000_003B);
    ahb(1'b1, `SSTX_OFF_HOLD, 32'h0000_00A5);
    ahb(1'b1, `SSTX_OFF_HOLD, 32'h0000_003C);
    ahb(1'b1, `SSTX_OFF_ISTAT, 32'h0000_0003);
    ahb(1'b0, `SSTX_OFF_STAT, 32'h0000_0000);
    chk("stat full", 32'h0000_0008, rd & 32'h0000_0009);
    chk("oe_n", 32'h0000_0000, {31'h0, serialDataOe_n});
    ahb(1'b1, `SSTX_OFF_CTRL, 32'h0000_003F);
    frame(1'b0, 8'hA5);
    ahb(1'b0, `SSTX_OFF_STAT, 32'h0000_0000);
    chk("stat tbe", 32'h0000_0001, rd & 32'h0000_0001);
    chk("wakeReq", 32'h0000_0001, {31'h0, wakeReq});
    chk("isrCall", 32'h0000_0001, {31'h0, isrCall});
    ahb(1'b0, `SSTX_OFF_CTRL, 32'h0000_0000);
    chk("ctrl", 32'h0000_003B, rd);
    ahb(1'b0, `SSTX_OFF_ISTAT, 32'h0000_0000);
    chk("istat", 32'h0000_0003, rd & 32'h0000_0003);
    ahb(1'b1, `SSTX_OFF_IMASK, 32'h0000_0001);
    @(posedge clk);
    chk("irq on", 32'h0000_0001, {31'h0, irq});
    ahb(1'b1, `SSTX_OFF_IMASK, 32'h0000_0000);
    @(posedge clk);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    ahb(1'b1, `SSTX_OFF_HOLD, 32'h0000_0081);
    ahb(1'b0, `SSTX_OFF_STAT, 32'h0000_0000);
    chk("stat refill", 32'h0000_0008, rd & 32'h0000_0009);
    ahb(1'b1, `SSTX_OFF_ISTAT, 32'h0000_0003);
    ahb(1'b1, `SSTX_OFF_IMASK, 32'h0000_0001);
    @(posedge clk);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    ahb(1'b1, `SSTX_OFF_WAKE, 32'h0000_0000);
    ahb(1'b0, 12'h040, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, rd);
    chk("wake clr", 32'h0000_0000, {30'h0, wakeReq, isrCall});
    frame(1'b1, 8'h3C);
  endtask

  // Wake without the global enable: processor resumes, no service call
  task automatic sleep_no_gie;
    ahb(1'b1, `SSTX_OFF_HOLD, 32'h0000_005A);
    ahb(1'b1, `SSTX_OFF_CTRL, 32'h0000_001F);
    frame(1'b0, 8'h81);
    chk("wake no gie", 32'h0000_0002, {30'h0, wakeReq, isrCall});
  endtask

  task automatic other_mode;
    ahb(1'b1, `SSTX_OFF_CTRL, 32'h0000_0002);
    ahb(1'b0, `SSTX_OFF_CTRL, 32'h0000_0000);
    chk("ctrl other", 32'h0000_0002, rd);
    chk("oe_n off", 32'h0000_0001, {31'h0, serialDataOe_n});
    chk("dataOut idle", 32'h0000_0001, {31'h0, serialDataOut});
    ahb(1'b0, `SSTX_OFF_STAT, 32'h0000_0000);
    chk("stat idle", 32'h0000_0000, rd & 32'h0000_0004);
  endtask

  task automatic finishTest;
    $display("errors %0d comparisons %0d", numErrors, cmpCount);
    if (numErrors == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    numErrors = 0;
    cmpCount = 0;
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    go = 1'b0;
    slow = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    reset_values();
    sleep_transmit();
    sleep_no_gie();
    other_mode();
    finishTest();
  end

  initial begin
    #100_000;
    numErrors++;
    finishTest();
  end
endmodule
